/* File: sim/ssc_peer_model.sv */
// far-side serial peripheral and external clock source
`timescale 1ns/1ps
module ssc_peer_model (
	// clock
	input  wire logic        mclk,
	// device pins
	input  wire logic        sckOut,
	input  wire logic        sckOe,
	input  wire logic        soPin,
	output logic             sckIn,
	output logic             siPin,
	// scenario control
	input  wire logic [15:0] txWord,
	input  wire logic [3:0]  extHalf,
	input  wire logic        extGo,
	input  wire logic [4:0]  extCount,
	output logic      [23:0] rxWord,
	output logic      [4:0]  bitCnt
);
	logic       sckLine;
	logic [3:0] idleCnt = 4'h0;
	logic       idleTog = 1'b0;
	logic       txBit   = 1'b0;
	logic       idle;
	logic [4:0] bitIdx  = 5'h00;
	logic [4:0] left    = 5'h00;
	logic [4:0] ph      = 5'h00;
	logic [4:0] lastPh;
	initial rxWord = 24'h0;
	initial bitCnt = 5'h00;
	// one clock pin, driven by whoever owns it
	assign sckLine = sckOe ? sckOut : sckIn;
	// external clock idles high, runs only when asked
	assign sckIn   = !(left != 5'h00 && ph < {1'b0, extHalf});
	assign lastPh  = {extHalf, 1'b0} - 5'h01;
	// data line follows its bit as soon as the clock falls
	assign idle    = idleCnt > 4'h8 && sckLine;
	// released data line wanders between frames
	assign siPin   = idle ? idleTog : txBit;
	always @(posedge mclk) begin
		idleTog <= !idleTog;
		idleCnt <= !sckLine ? 4'h0 : idleCnt + {3'h0, idleCnt != 4'hf};
		if (extGo) begin
			left <= extCount;
			ph   <= 5'h00;
		end else if (left != 5'h00) begin
			ph   <= (ph == lastPh) ? 5'h00 : ph + 5'h01;
			left <= left - {4'h0, ph == lastPh};
		end
	end
	always @(negedge sckLine) begin
		if (idleCnt > 4'h8) begin
			bitIdx = 5'h00;
			bitCnt = 5'h00;
			rxWord = 24'h0;
		end
		txBit  = txWord[bitIdx[3:0]];
		bitIdx = bitIdx + 5'h01;
	end
	// capture on rising edge, first bit ends lowest
	always @(posedge sckLine) begin
		rxWord = {soPin, rxWord[23:1]};
		bitCnt = bitCnt + 5'h01;
	end
endmodule // ssc_peer_model

/* File: sim/tb_top.sv */
// self-checking bench for the serial channel
`timescale 1ns/1ps
module tb_top;
	logic        mclk     = 1'b0;
	logic        rst_n    = 1'b0;
	logic        hsel     = 1'b0;
	logic [31:0] haddr    = 32'h0;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [31:0] hwdata   = 32'h0;
	logic        subClkIn = 1'b0;
	logic [2:0]  subDiv   = 3'h0;
	logic [15:0] txWord   = 16'hbeef;
	logic        extGo    = 1'b0;
	logic [4:0]  extCount = 5'h00;
	logic        hreadyout, hresp, sckIn, siPin, sckOut, sckOe, soPin, irq;
	logic [31:0] hrdata;
	logic [23:0] rxWord;
	logic [4:0]  bitCnt;
	logic [31:0] d;
	int          miscompares = 0;
	int          checks_done = 0;
	int          p, n, w;
	logic [7:0]  ctrlTab [4] = '{8'h06, 8'h46, 8'h66, 8'h36};
	logic [1:0]  tailTab [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
	logic [10:0] divTab  [8] = '{11'h400, 11'h100, 11'h040, 11'h020,
		11'h010, 11'h008, 11'h004, 11'h020};
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		subDiv   <= subDiv + 3'h1;
		subClkIn <= subDiv[2];
	end
	ssc_top i_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .sckIn(sckIn), .siPin(siPin),
		.subClkIn(subClkIn), .sckOut(sckOut), .sckOe(sckOe),
		.soPin(soPin), .irq(irq));
	ssc_peer_model i_peer (.mclk(mclk), .sckOut(sckOut), .sckOe(sckOe),
		.soPin(soPin), .sckIn(sckIn), .siPin(siPin), .txWord(txWord),
		.extHalf(4'h5), .extGo(extGo), .extCount(extCount),
		.rxWord(rxWord), .bitCnt(bitCnt));
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic timeOut();
		miscompares++;
		$display("wrong value at %0t: wait ran out", $time);
		give_verdict();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic waitReady();
		int k;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		if (hreadyout !== 1'b1) timeOut();
	endtask
	task automatic busAddr(input logic [15:0] idx, input logic wr);
		@(posedge mclk);
		hsel   <= 1'b1;
		haddr  <= {14'h0, idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= wr;
		waitReady();
		hsel   <= 1'b0;
		htrans <= 2'h0;
	endtask
	task automatic busWrite(input logic [15:0] idx, input logic [7:0] v);
		busAddr(idx, 1'b1);
		hwdata <= {24'h0, v};
		waitReady();
	endtask
	task automatic busRead(input logic [15:0] idx);
		busAddr(idx, 1'b0);
		waitReady();
		d = hrdata;
	endtask
	task automatic rdChk(input logic [15:0] idx, input logic [7:0] v);
		busRead(idx);
		chk(d, {24'h0, v});
	endtask
	task automatic settle();
		repeat (2) @(posedge mclk);
	endtask
	task automatic waitIrq();
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 5000) begin
			@(posedge mclk);
			k++;
		end
		if (irq !== 1'b1) timeOut();
	endtask
	task automatic extPulses(input logic [4:0] c);
		@(posedge mclk);
		extCount <= c;
		extGo    <= 1'b1;
		@(posedge mclk);
		extGo    <= 1'b0;
	endtask
	task automatic sckPeriod();
		int k, t0, f;
		logic prev;
		f = 0;
		t0 = 0;
		p = 0;
		prev = sckOut;
		for (k = 0; k < 4000 && f < 2; k++) begin
			@(posedge mclk);
			if (prev === 1'b1 && sckOut === 1'b0) begin
				f++;
				if (f == 1) t0 = k;
				else p = k - t0;
			end
			prev = sckOut;
		end
		if (f < 2) timeOut();
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rdChk(ssc_pkg::IDX_CTRL, 8'h00);
		rdChk(ssc_pkg::IDX_STAT, 8'h9c);
		rdChk(ssc_pkg::IDX_CKSTP, 8'hff);
		rdChk(ssc_pkg::IDX_IRQMSK, 8'h00);
		chk(32'(hresp), 32'h0);
		busWrite(16'h0100, 8'h5a);
		rdChk(16'h0100, 8'h00);
		busWrite(ssc_pkg::IDX_STAT, 8'h20);
		rdChk(ssc_pkg::IDX_STAT, 8'h9c);
		busWrite(ssc_pkg::IDX_IRQMSK, 8'h01);
		for (int i = 0; i < 4; i++) begin
			busWrite(ssc_pkg::IDX_CTRL, ctrlTab[i]);
			busWrite(ssc_pkg::IDX_DUPPER, 8'h12);
			busWrite(ssc_pkg::IDX_DLOWER, 8'h34);
			busWrite(ssc_pkg::IDX_STAT, 8'h01);
			busRead(ssc_pkg::IDX_STAT);
			chk(32'(d[0]), 32'h1);
			chk(32'(sckOe), 32'h1);
			waitIrq();
			w = ctrlTab[i][6] ? 16 : 8;
			n = w + (ctrlTab[i][5] ? 2 : 0);
			chk(32'(bitCnt), 32'(n));
			d = 32'(rxWord >> (24 - n));
			chk(d & (ctrlTab[i][6] ? 32'hffff : 32'hff),
				ctrlTab[i][6] ? 32'h1234 : 32'h34);
			chk((d >> w) & 32'h3, 32'(tailTab[i]));
			rdChk(ssc_pkg::IDX_IRQST, 8'h01);
			settle();
			chk(32'(irq), 32'h0);
			busRead(ssc_pkg::IDX_STAT);
			chk(32'(d[0]), 32'h0);
			if (ctrlTab[i][5] == 1'b0) begin
				rdChk(ssc_pkg::IDX_DLOWER, 8'hef);
				if (w == 16) rdChk(ssc_pkg::IDX_DUPPER, 8'hbe);
			end
		end
		for (int k = 0; k < 8; k++) begin
			busWrite(ssc_pkg::IDX_CTRL, 8'(k));
			busWrite(ssc_pkg::IDX_STAT, 8'h01);
			sckPeriod();
			chk(32'(p), 32'(divTab[k]));
			busWrite(ssc_pkg::IDX_CTRL, 8'h06);
			busRead(ssc_pkg::IDX_STAT);
			chk(32'(d[0]), 32'h0);
		end
		busWrite(ssc_pkg::IDX_CTRL, 8'h86);
		sckPeriod();
		chk(32'(p), 32'h4);
		busWrite(ssc_pkg::IDX_STAT, 8'h01);
		busRead(ssc_pkg::IDX_STAT);
		chk(32'(d[0]), 32'h0);
		busWrite(ssc_pkg::IDX_CTRL, 8'h08);
		settle();
		chk(32'(sckOe), 32'h0);
		txWord <= 16'h005a;
		busWrite(ssc_pkg::IDX_DLOWER, 8'hc3);
		busWrite(ssc_pkg::IDX_STAT, 8'h01);
		extPulses(5'h08);
		waitIrq();
		chk(32'(rxWord >> 16), 32'hc3);
		rdChk(ssc_pkg::IDX_DLOWER, 8'h5a);
		rdChk(ssc_pkg::IDX_IRQST, 8'h01);
		extPulses(5'h01);
		n = 0;
		do begin
			busRead(ssc_pkg::IDX_STAT);
			n++;
		end while (d[5] !== 1'b1 && n < 20);
		chk(32'(d[5]), 32'h1);
		chk(32'(irq), 32'h0);
		busWrite(ssc_pkg::IDX_IRQMSK, 8'h03);
		settle();
		chk(32'(irq), 32'h1);
		busWrite(ssc_pkg::IDX_STAT, 8'h20);
		busRead(ssc_pkg::IDX_STAT);
		chk(32'(d[5]), 32'h1);
		busWrite(ssc_pkg::IDX_STAT, 8'h00);
		busRead(ssc_pkg::IDX_STAT);
		chk(32'(d[5]), 32'h0);
		busWrite(ssc_pkg::IDX_STAT, 8'h40);
		rdChk(ssc_pkg::IDX_STAT, 8'hdc);
		chk(32'(soPin), 32'h1);
		rdChk(ssc_pkg::IDX_IRQST, 8'h02);
		settle();
		chk(32'(irq), 32'h0);
		busWrite(ssc_pkg::IDX_CTRL, 8'h76);
		busWrite(ssc_pkg::IDX_CKSTP, 8'h7f);
		rdChk(ssc_pkg::IDX_CTRL, 8'h00);
		rdChk(ssc_pkg::IDX_DLOWER, 8'h00);
		rdChk(ssc_pkg::IDX_CKSTP, 8'h7f);
		chk(32'(soPin), 32'h0);
		busWrite(ssc_pkg::IDX_CKSTP, 8'hff);
		give_verdict();
	end
endmodule // tb_top

/* File: verilog/ssc_pkg.sv */
// constants for the synchronous serial channel
package ssc_pkg;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_CTRL   = 16'hffa0;
	localparam logic [15:0] IDX_STAT   = 16'hffa1;
	localparam logic [15:0] IDX_DUPPER = 16'hffa2;
	localparam logic [15:0] IDX_DLOWER = 16'hffa3;
	localparam logic [15:0] IDX_IRQST  = 16'hffa4;
	localparam logic [15:0] IDX_IRQMSK = 16'hffa5;
	localparam logic [15:0] IDX_CKSTP  = 16'hfffa;
	// reset values
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] STAT_RST  = 8'h9c;
	localparam logic [7:0] CKSTP_RST = 8'hff;
	localparam logic [7:0] DATA_RST  = 8'h00;
	// control bit positions
	localparam int CTRL_MODE_HI  = 7;
	localparam int CTRL_MODE_LO  = 6;
	localparam int CTRL_TAIL_EN  = 5;
	localparam int CTRL_TAIL_SEL = 4;
	localparam int CTRL_CLK_SRC  = 3;
	localparam int CTRL_RATE_HI  = 2;
	// status bit positions
	localparam int STAT_SOL  = 6;
	localparam int STAT_OVERRUN_FLAG = 5;
	localparam int STAT_TAIL_SENDING_FLAG = 1;
	localparam int STAT_STF  = 0;
	// standby bit and interrupt bits
	localparam int CKSTP_RUN = 7;
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_OVERRUN_FLAG  = 1;
	// operating modes
	typedef enum logic [1:0] {
		MODE_8    = 2'h0,
		MODE_16   = 2'h1,
		MODE_CONT = 2'h2,
		MODE_RSV  = 2'h3
	} ssc_mode_type;
	typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_TAIL} ssc_state_type;
	// last bit index per word length and tail
	localparam logic [4:0] LAST_8    = 5'h07;
	localparam logic [4:0] LAST_16   = 5'h0f;
	localparam logic [4:0] LAST_TAIL = 5'h01;
	// tail patterns, sent lsb first
	localparam logic [1:0] HOLD_TAIL  = 2'h1;
	localparam logic [1:0] LATCH_TAIL = 2'h2;
	// half period minus one, in mclk cycles, per rate code
	localparam logic [2:0] RATE_SUB = 3'h7;
	localparam logic [8:0] HALF_LOAD [8] = '{
		9'h1ff, 9'h07f, 9'h01f, 9'h00f, 9'h007, 9'h003, 9'h001, 9'h000
	};
endpackage

/* File: verilog/ssc_prescaler.sv */
// serial clock prescaler, half-period tick
`timescale 1ns/1ps
module ssc_prescaler (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// control
	input  wire logic       run,
	input  wire logic [2:0] rateSel,
	input  wire logic       subRise,
	// tick out
	output logic            halfTick
);
	logic [8:0] cntFf;
	logic [8:0] nxt_cnt;
	logic       subPhFf;
	logic       nxt_subPh;
	logic       nxt_halfTick;

	always_comb begin
		nxt_cnt      = cntFf;
		nxt_subPh    = subPhFf;
		nxt_halfTick = 1'b0;
		if (!run) begin
			nxt_cnt   = '0;
			nxt_subPh = 1'b0;
		end else if (rateSel == ssc_pkg::RATE_SUB) begin
			// two subclock rising edges per half period
			if (subRise) begin
				nxt_halfTick = subPhFf;
				nxt_subPh    = ~subPhFf;
			end
		end else if (cntFf == '0) begin
			nxt_halfTick = 1'b1;
			nxt_cnt      = ssc_pkg::HALF_LOAD[rateSel];
		end else begin
			nxt_cnt = cntFf - 9'h001;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cntFf    <= '0;
			subPhFf  <= 1'b0;
			halfTick <= 1'b0;
		end else begin
			cntFf    <= nxt_cnt;
			subPhFf  <= nxt_subPh;
			halfTick <= nxt_halfTick;
		end
	end
endmodule // ssc_prescaler

/* File: verilog/ssc_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ssc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// async in, synced out
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] stage1Ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage1Ff <= '0;
			dout     <= '0;
		end else begin
			stage1Ff <= din;
			dout     <= stage1Ff;
		end
	end
endmodule // ssc_sync

/* File: verilog/ssc_top.sv */
// synchronous serial channel with ahb-lite registers
//
// Overview of operation
// - mode field selects 8, 16, continuous
// - control write aborts running transfer
// - control bit 5 appends tail mark
// - control bit 4 picks hold/latch tail
// - control bit 3 picks clock source
// - rate field picks prescaler division
// - completion raises interrupt request
// - clock pin bidirectional, data pins one-way
// - status bit 7 reads one always
// - overrun flag cleared only by writing zero or by standby
// - control register resets to zero
// - status register resets to 9c
// - start flag begins transfer, clears at end
// - late external clock sets overrun
// - lsb first, upper feeds lower in 16-bit mode
// - standby bit clear resets registers
`timescale 1ns/1ps
module ssc_top (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// serial pins
	input  wire logic        sckIn,
	input  wire logic        siPin,
	input  wire logic        subClkIn,
	output logic             sckOut,
	output logic             sckOe,
	output logic             soPin,
	// interrupt
	output logic             irq
);
	ssc_pkg::ssc_state_type stateFf, nxt_state;
	logic [7:0]  ctrlFf, nxt_ctrl;
	logic [7:0]  ckstpFf, nxt_ckstp;
	logic [15:0] shRegFf, nxt_shReg;
	logic [4:0]  bitCntFf, nxt_bitCnt;
	logic        stfFf, nxt_stf;
	logic        mtrfFf, nxt_tail_sending_flag;
	logic        orerFf, nxt_overrun_flag;
	logic        doneFf, nxt_done;
	logic [1:0]  irqStatFf, nxt_irqStat;
	logic [1:0]  maskFf, nxt_mask;
	logic        wPendFf, nxt_wPend;
	logic [15:0] wIdxFf, nxt_wIdx;
	logic        sckPrevFf, subPrevFf, riseDlyFf;
	logic [31:0] nxt_hrdata;
	logic        nxt_soPin, nxt_sckOut, nxt_sckOe, nxt_irq;
	logic [2:0]  synced;
	logic        sckS, siS, subS;
	logic        halfTick, preRun, extClk, fallE, riseE;
	logic        accept, doneEv, orerEv, tailEn;
	logic [4:0]  lastBit;
	logic [1:0]  tailPat;
	logic [7:0]  statVal, wd;
	logic [15:0] aIdx;
	ssc_pkg::ssc_mode_type mode;

	// pins pass two flops before use
	ssc_sync #(.W(3)) uSync (
		.mclk (mclk),
		.rst_n(rst_n),
		.din  ({sckIn, siPin, subClkIn}),
		.dout (synced)
	);
	assign sckS = synced[2];
	assign siS  = synced[1];
	assign subS = synced[0];

	assign mode    = ssc_pkg::ssc_mode_type'(ctrlFf[7:6]);
	assign extClk  = ctrlFf[ssc_pkg::CTRL_CLK_SRC];
	assign tailEn  = ctrlFf[ssc_pkg::CTRL_TAIL_EN];
	assign tailPat = ctrlFf[ssc_pkg::CTRL_TAIL_SEL] ? ssc_pkg::LATCH_TAIL
		: ssc_pkg::HOLD_TAIL;
	assign lastBit = (mode == ssc_pkg::MODE_16) ? ssc_pkg::LAST_16
		: ssc_pkg::LAST_8;
	assign preRun  = !extClk && ckstpFf[ssc_pkg::CKSTP_RUN]
		&& (stateFf != ssc_pkg::ST_IDLE || mode == ssc_pkg::MODE_CONT);

	ssc_prescaler uPre (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.run     (preRun),
		.rateSel (ctrlFf[ssc_pkg::CTRL_RATE_HI:0]),
		.subRise (subS && !subPrevFf),
		.halfTick(halfTick)
	);

	// same edge convention for both sources
	assign fallE = extClk ? (sckPrevFf && !sckS) : (halfTick && sckOut);
	// internal source: sample a cycle after the rise, synced data lags
	assign riseE = extClk ? (!sckPrevFf && sckS) : riseDlyFf;

	assign accept  = hsel && htrans[1] && hready;
	assign aIdx    = haddr[17:2];
	assign wd      = hwdata[7:0];
	// fixed ones in bits 7 and 4..2
	assign statVal = ssc_pkg::STAT_RST | {1'b0, soPin, orerFf, 3'h0,
		mtrfFf, stfFf};

	always_comb begin
		nxt_state   = stateFf;
		nxt_ctrl    = ctrlFf;
		nxt_ckstp   = ckstpFf;
		nxt_shReg   = shRegFf;
		nxt_bitCnt  = bitCntFf;
		nxt_stf     = stfFf;
		nxt_tail_sending_flag    = mtrfFf;
		nxt_overrun_flag    = orerFf;
		nxt_done    = doneFf;
		nxt_irqStat = irqStatFf;
		nxt_mask    = maskFf;
		nxt_soPin   = soPin;
		nxt_sckOut  = sckOut;
		nxt_hrdata  = hrdata;
		nxt_wPend   = accept && hwrite;
		nxt_wIdx    = accept ? aIdx : wIdxFf;
		doneEv      = 1'b0;
		orerEv      = 1'b0;
		// clock pin drives only with internal source
		nxt_sckOe   = !extClk;
		if (!preRun) begin
			nxt_sckOut = 1'b1;
		end else if (halfTick) begin
			nxt_sckOut = ~sckOut;
		end
		// serial engine
		if (fallE) begin
			case (stateFf)
				ssc_pkg::ST_DATA: nxt_soPin = shRegFf[0];
				ssc_pkg::ST_TAIL: nxt_soPin = tailPat[bitCntFf[0]];
				default: ;
			endcase
		end
		if (riseE) begin
			case (stateFf)
				ssc_pkg::ST_DATA: begin
					nxt_bitCnt = bitCntFf + 5'h01;
					if (mode == ssc_pkg::MODE_16) begin
						nxt_shReg = {siS, shRegFf[15:1]};
					end else begin
						nxt_shReg[7:0] = {siS, shRegFf[7:1]};
					end
					if (bitCntFf == lastBit) begin
						nxt_bitCnt = '0;
						if (tailEn) begin
							nxt_state = ssc_pkg::ST_TAIL;
							nxt_tail_sending_flag  = 1'b1;
						end else begin
							doneEv = 1'b1;
						end
					end
				end
				ssc_pkg::ST_TAIL: begin
					nxt_bitCnt = bitCntFf + 5'h01;
					if (bitCntFf == ssc_pkg::LAST_TAIL) begin
						doneEv = 1'b1;
					end
				end
				default: begin
					orerEv = extClk && doneFf;
				end
			endcase
		end
		if (doneEv) begin
			// start flag clears at the end
			nxt_state = ssc_pkg::ST_IDLE;
			nxt_stf   = 1'b0;
			nxt_tail_sending_flag  = 1'b0;
			nxt_done  = 1'b1;
		end
		// bus address phase: read data registered here
		if (accept && !hwrite) begin
			nxt_hrdata = '0;
			if (aIdx == ssc_pkg::IDX_CTRL) begin
				nxt_hrdata[7:0] = ctrlFf;
			end else if (aIdx == ssc_pkg::IDX_STAT) begin
				nxt_hrdata[7:0] = statVal;
			end else if (aIdx == ssc_pkg::IDX_DUPPER) begin
				nxt_hrdata[7:0] = shRegFf[15:8];
			end else if (aIdx == ssc_pkg::IDX_DLOWER) begin
				nxt_hrdata[7:0] = shRegFf[7:0];
			end else if (aIdx == ssc_pkg::IDX_IRQST) begin
				nxt_hrdata[1:0] = irqStatFf;
				nxt_irqStat     = '0;
			end else if (aIdx == ssc_pkg::IDX_IRQMSK) begin
				nxt_hrdata[1:0] = maskFf;
			end else if (aIdx == ssc_pkg::IDX_CKSTP) begin
				nxt_hrdata[7:0] = ckstpFf;
			end
		end
		// bus data phase writes
		if (wPendFf) begin
			if (wIdxFf == ssc_pkg::IDX_CTRL) begin
				nxt_ctrl = wd;
				nxt_state  = ssc_pkg::ST_IDLE;
				nxt_stf    = 1'b0;
				nxt_tail_sending_flag   = 1'b0;
				nxt_bitCnt = '0;
			end else if (wIdxFf == ssc_pkg::IDX_STAT) begin
				if (!wd[ssc_pkg::STAT_OVERRUN_FLAG]) begin
					nxt_overrun_flag = 1'b0;
				end
				if (stateFf == ssc_pkg::ST_IDLE && !tailEn) begin
					nxt_soPin = wd[ssc_pkg::STAT_SOL];
				end
				if (wd[ssc_pkg::STAT_STF] && stateFf == ssc_pkg::ST_IDLE
					&& mode != ssc_pkg::MODE_CONT) begin
					nxt_state  = ssc_pkg::ST_DATA;
					nxt_stf    = 1'b1;
					nxt_bitCnt = '0;
					nxt_done   = 1'b0;
				end
			end else if (wIdxFf == ssc_pkg::IDX_DUPPER) begin
				nxt_shReg[15:8] = wd;
			end else if (wIdxFf == ssc_pkg::IDX_DLOWER) begin
				nxt_shReg[7:0] = wd;
			end else if (wIdxFf == ssc_pkg::IDX_IRQMSK) begin
				nxt_mask = wd[1:0];
			end else if (wIdxFf == ssc_pkg::IDX_CKSTP) begin
				nxt_ckstp = wd;
			end
		end
		// events win over bus clears; standby clears overrun regardless
		if (orerEv) begin
			nxt_overrun_flag = 1'b1;
		end
		if (doneEv) begin
			nxt_irqStat[ssc_pkg::IRQ_DONE] = 1'b1;
		end
		if (orerEv) begin
			nxt_irqStat[ssc_pkg::IRQ_OVERRUN_FLAG] = 1'b1;
		end
		if (!ckstpFf[ssc_pkg::CKSTP_RUN]) begin
			nxt_ctrl   = ssc_pkg::CTRL_RST;
			nxt_state  = ssc_pkg::ST_IDLE;
			nxt_stf    = 1'b0;
			nxt_tail_sending_flag   = 1'b0;
			nxt_overrun_flag   = 1'b0;
			nxt_done   = 1'b0;
			nxt_bitCnt = '0;
			nxt_soPin  = 1'b0;
			nxt_shReg  = {ssc_pkg::DATA_RST, ssc_pkg::DATA_RST};
		end
		nxt_irq = |(nxt_irqStat & nxt_mask);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stateFf   <= ssc_pkg::ST_IDLE;
			ctrlFf    <= ssc_pkg::CTRL_RST;
			ckstpFf   <= ssc_pkg::CKSTP_RST;
			shRegFf   <= {ssc_pkg::DATA_RST, ssc_pkg::DATA_RST};
			bitCntFf  <= '0;
			stfFf     <= 1'b0;
			mtrfFf    <= 1'b0;
			orerFf    <= 1'b0;
			doneFf    <= 1'b0;
			irqStatFf <= '0;
			maskFf    <= '0;
			wPendFf   <= 1'b0;
			wIdxFf    <= '0;
			sckPrevFf <= 1'b0;
			subPrevFf <= 1'b0;
			riseDlyFf <= 1'b0;
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			soPin     <= 1'b0;
			sckOut    <= 1'b1;
			sckOe     <= 1'b1;
			irq       <= 1'b0;
		end else begin
			stateFf   <= nxt_state;
			ctrlFf    <= nxt_ctrl;
			ckstpFf   <= nxt_ckstp;
			shRegFf   <= nxt_shReg;
			bitCntFf  <= nxt_bitCnt;
			stfFf     <= nxt_stf;
			mtrfFf    <= nxt_tail_sending_flag;
			orerFf    <= nxt_overrun_flag;
			doneFf    <= nxt_done;
			irqStatFf <= nxt_irqStat;
			maskFf    <= nxt_mask;
			wPendFf   <= nxt_wPend;
			wIdxFf    <= nxt_wIdx;
			sckPrevFf <= sckS;
			subPrevFf <= subS;
			riseDlyFf <= halfTick && !sckOut && preRun;
			hrdata    <= nxt_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			soPin     <= nxt_soPin;
			sckOut    <= nxt_sckOut;
			sckOe     <= nxt_sckOe;
			irq       <= nxt_irq;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_ctrlWrBusy;
		wPendFf && wIdxFf == ssc_pkg::IDX_CTRL && stateFf != ssc_pkg::ST_IDLE;
	endsequence
	sequence s_dataEnd;
		riseE && stateFf == ssc_pkg::ST_DATA && bitCntFf == lastBit;
	endsequence

	a_ctrl_wr_abort: assert property (s_ctrlWrBusy |=> !stfFf && !mtrfFf)
		else $error("control write did not abort transfer");
	a_tail_follows: assert property (s_dataEnd and tailEn |=>
		stateFf == ssc_pkg::ST_TAIL && mtrfFf && stfFf)
		else $error("tail did not follow data");
	a_sck_dir: assert property (##1 sckOe == !$past(extClk))
		else $error("clock pin direction wrong");
	a_done_irq: assert property (doneEv |=> irqStatFf[ssc_pkg::IRQ_DONE]
		##1 irq == |(irqStatFf & maskFf))
		else $error("completion not flagged");
	a_stat_fixed: assert property (accept && !hwrite
		&& aIdx == ssc_pkg::IDX_STAT |=> hrdata[7] && hrdata[4:2] == 3'h7)
		else $error("status fixed bits wrong");
	a_overrun_flag_keep: assert property (wPendFf && wIdxFf == ssc_pkg::IDX_STAT
		&& wd[ssc_pkg::STAT_OVERRUN_FLAG] && orerFf
		&& ckstpFf[ssc_pkg::CKSTP_RUN] |=> orerFf)
		else $error("overrun cleared by a one");
	a_start_go: assert property (!stfFf ##1 stfFf |->
		stateFf == ssc_pkg::ST_DATA && bitCntFf == 5'h00)
		else $error("start flag without transfer");
	a_overrun_set: assert property (riseE && extClk && doneFf
		&& stateFf == ssc_pkg::ST_IDLE && ckstpFf[ssc_pkg::CKSTP_RUN]
		|=> orerFf [*2])
		else $error("overrun not set");
	a_lsb_first: assert property (fallE && stateFf == ssc_pkg::ST_DATA
		&& ckstpFf[ssc_pkg::CKSTP_RUN] |=> soPin == $past(shRegFf[0]))
		else $error("data bit order wrong");
	a_stby_reset: assert property (!ckstpFf[ssc_pkg::CKSTP_RUN] |=>
		ctrlFf == ssc_pkg::CTRL_RST && !stfFf && !orerFf)
		else $error("standby did not reset channel");
endmodule // ssc_top
